// file: core/spms_pkg.sv
// Shared constants and types for the supply phase and mode sequencer.
package spms_pkg;

  // ************************************************************
  // Timing
  // ************************************************************

  // System clock rate in kHz (10 MHz, 100 ns period).
  localparam int CLK_FREQ_KHZ = 10000;
  // Oscillator switching frequency in kHz.
  localparam int OSC_FREQ_KHZ = 100;
  // Largest share of an oscillator cycle that may carry an on-time, in percent.
  localparam int MAX_DUTY_PCT = 80;
  // Percent scale used to turn the duty figure into cycles.
  localparam int PCT_FULL = 100;
  // Oscillator period in system clocks.
  localparam int OSC_PERIOD_CYC = CLK_FREQ_KHZ / OSC_FREQ_KHZ;
  // Longest on-time in system clocks; a longest time rounds down.
  localparam int MAX_ON_CYC = (OSC_PERIOD_CYC * MAX_DUTY_PCT) / PCT_FULL;

  // ************************************************************
  // Comparator input bundle
  // ************************************************************

  // Number of asynchronous comparator inputs.
  localparam int CMP_W = 9;
  // Supply reached the start threshold.
  localparam int CMP_START = 0;
  // Supply fell to the lower working threshold.
  localparam int CMP_LOW_WORK = 1;
  // Supply fell to the undervoltage restart threshold.
  localparam int CMP_UVLO = 2;
  // Supply above the fixed overvoltage level.
  localparam int CMP_VCC_OVER = 3;
  // Quick overvoltage from the demagnetization current.
  localparam int CMP_QOVP = 4;
  // Current-sense comparator tripped.
  localparam int CMP_CS = 5;
  // Pulse-width comparator ended the on-time.
  localparam int CMP_PWM = 6;
  // Transformer demagnetization complete.
  localparam int CMP_DEMAG = 7;
  // Demagnetization input current below the direct-return level.
  localparam int CMP_DEMAG_LOW = 8;

  // ************************************************************
  // Types and reset values
  // ************************************************************

  // Operating phases of the supply.
  typedef enum logic [1:0] {
    PH_STARTUP,
    PH_SWITCH,
    PH_LATCHED
  } spms_phase_t;

  // Mode latch value after reset: normal mode.
  localparam logic MODE_RST = 1'h0;
  // End-of-cycle status after reset: overcurrent value.
  localparam logic END_STATUS_RST = 1'h0;

endpackage

// file: core/spms_sync.sv
// Two-stage synchroniser for a bundle of asynchronous comparator levels.
`timescale 1ns/1ps
`default_nettype none

module spms_sync #(
  parameter int WIDTH = spms_pkg::CMP_W
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import spms_pkg::*;

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  // The first stage feeds only the second stage, so a metastable level never
  // reaches any decision logic.
  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  // Both stages clear on the synchronous reset.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;

endmodule

`default_nettype wire

// file: core/spms_sequencer.sv
// Phase, pulse and mode sequencing for an off-line switch-mode supply controller.
//
// Summary of operation
// - Each on-time end stores 1 for no overcurrent, 0 for overcurrent.
// - Supply at lower working threshold ends switching; end status keeps its value only if a width ending was seen.
// - On-time is cut at eighty percent of each oscillator cycle.
// - Latched-off phase, with no pulses, ends at the restart threshold.
// - Start-up after overcurrent ending enables source and clears the mode latch.
// - Start threshold ends start-up, disables the source, enters switching.
// - Normal mode sources no sense-pin current; full sense threshold applies.
// - Entering latched-off with no-overcurrent status sets the mode latch.
// - Start-up after no-overcurrent ending leaves the mode latch set.
// - Switching with mode set gives standby indication and sense-pin source.
// - Switching that saw no pulse-width ending clears the end status.
// - Low demagnetization current clears the mode latch at once, any phase.
// - Standby latched-off closes sleep bias switch and opens regulator switch.
// - Cycle start sets the pulse; width or current trip clears it.
// - Any overvoltage trip holds the output off until the next start-up.
// - Without demagnetization complete, the next oscillator cycle waits.
`timescale 1ns/1ps
`default_nettype none

module spms_sequencer #(
  parameter int OSC_PERIOD = spms_pkg::OSC_PERIOD_CYC,
  parameter int MAX_ON = spms_pkg::MAX_ON_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [spms_pkg::CMP_W-1:0] cmp_async,
  output logic gate_drive,
  output logic startup_src_en,
  output logic cs_source_en,
  output logic standby_ind,
  output logic sleep_bias_switch,
  output logic regulator_switch,
  output logic mode_pulsed,
  output logic end_status_latch,
  output logic overcurrent_flag,
  output logic no_overcurrent_flag,
  output logic ovp_latched,
  output spms_pkg::spms_phase_t phase
);
  import spms_pkg::*;

  localparam int CW = $clog2(OSC_PERIOD);
  localparam logic [CW-1:0] OSC_LAST = CW'(OSC_PERIOD - 1);
  localparam logic [CW-1:0] ON_LAST = CW'(MAX_ON - 1);

  // ************************************************************
  // Input synchronisation
  // ************************************************************
  logic [CMP_W-1:0] cmp_s;
  logic start_s;
  logic low_work_s;
  logic uvlo_s;
  logic ovp_s;
  logic cs_s;
  logic pwm_s;
  logic demag_complete;
  logic direct_normal_reset;

  // All comparators are asynchronous to mclk.
  spms_sync #(
    .WIDTH(CMP_W)
  ) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .async_in(cmp_async),
    .sync_out(cmp_s)
  );

  // Named views of the synchronised comparator levels.
  assign start_s = cmp_s[CMP_START];
  assign low_work_s = cmp_s[CMP_LOW_WORK];
  assign uvlo_s = cmp_s[CMP_UVLO];
  assign ovp_s = cmp_s[CMP_VCC_OVER] | cmp_s[CMP_QOVP];
  assign cs_s = cmp_s[CMP_CS];
  assign pwm_s = cmp_s[CMP_PWM];
  assign demag_complete = cmp_s[CMP_DEMAG];
  assign direct_normal_reset = cmp_s[CMP_DEMAG_LOW];

  // ************************************************************
  // State
  // ************************************************************
  spms_phase_t phase_ff;
  spms_phase_t nxt_phase;
  logic [CW-1:0] osc_cnt_ff;
  logic [CW-1:0] nxt_osc_cnt;
  logic gate_ff;
  logic nxt_gate;
  logic end_status_ff;
  logic nxt_end_status;
  logic mode_ff;
  logic nxt_mode;
  logic ovp_ff;
  logic nxt_ovp;
  logic pwm_seen_ff;
  logic nxt_pwm_seen;

  logic cycle_start;
  logic on_end;
  logic sw_exit;
  logic enter_startup;
  logic enter_latched;

  // Phase transition, cycle start and on-time end events used by the pulse and latch logic.
  always_comb begin
    sw_exit = (phase_ff == PH_SWITCH) && low_work_s;
    enter_latched = sw_exit;
    enter_startup = (phase_ff == PH_LATCHED) && uvlo_s;
    cycle_start = (phase_ff == PH_SWITCH) && !sw_exit && (osc_cnt_ff == OSC_LAST)
                  && demag_complete;
    on_end = gate_ff && (cs_s || pwm_s || (osc_cnt_ff == ON_LAST));
  end

  // ************************************************************
  // Phase sequence
  // ************************************************************
  // Start-up charges the supply, switching runs pulses, latched-off idles.
  always_comb begin
    nxt_phase = phase_ff;
    case (phase_ff)
      PH_STARTUP: begin
        if (start_s) begin
          nxt_phase = PH_SWITCH;
        end
      end
      PH_SWITCH: begin
        if (low_work_s) begin
          nxt_phase = PH_LATCHED;
        end
      end
      PH_LATCHED: begin
        if (uvlo_s) begin
          nxt_phase = PH_STARTUP;
        end
      end
      default: begin
        nxt_phase = PH_STARTUP;
      end
    endcase
  end

  // ************************************************************
  // Oscillator and pulse latch
  // ************************************************************
  // The oscillator parks at its last count outside switching, so the first
  // cycle of a new switching phase starts as soon as demagnetization allows.
  always_comb begin
    nxt_osc_cnt = osc_cnt_ff;
    if (phase_ff != PH_SWITCH) begin
      nxt_osc_cnt = OSC_LAST;
    end else if (osc_cnt_ff == OSC_LAST) begin
      if (demag_complete) begin
        nxt_osc_cnt = '0;
      end else begin
        nxt_osc_cnt = OSC_LAST;
      end
    end else begin
      nxt_osc_cnt = osc_cnt_ff + 1'b1;
    end
  end

  // Only the cycle start sets the pulse, so one pulse per cycle at most.
  // The duty cap ends the pulse even if regulation wants it longer.
  always_comb begin
    nxt_gate = gate_ff;
    if (cycle_start && !ovp_ff && !ovp_s) begin
      nxt_gate = 1'b1;
    end else if (on_end || sw_exit || ovp_ff || ovp_s || phase_ff != PH_SWITCH) begin
      nxt_gate = 1'b0;
    end
  end

  // ************************************************************
  // End-of-cycle status and mode latch
  // ************************************************************
  // The status records how each on-time ended. A pulse cut only by the end of
  // switching or an overvoltage is not a real ending and leaves it alone.
  always_comb begin
    nxt_end_status = end_status_ff;
    nxt_pwm_seen = pwm_seen_ff;
    if (on_end) begin
      nxt_end_status = !cs_s;
      nxt_pwm_seen = pwm_seen_ff || !cs_s;
    end
    if (sw_exit && !(on_end && !cs_s) && !pwm_seen_ff) begin
      nxt_end_status = 1'b0;
    end
    if (phase_ff == PH_STARTUP) begin
      nxt_pwm_seen = 1'b0;
    end
  end

  // The direct reset wins over every phase-driven update so that a secondary
  // wake-up does not wait for a whole burst sequence.
  always_comb begin
    nxt_mode = mode_ff;
    if (enter_latched && nxt_end_status) begin
      nxt_mode = 1'b1;
    end
    if (enter_startup && !end_status_ff) begin
      nxt_mode = 1'b0;
    end
    if (direct_normal_reset) begin
      nxt_mode = 1'b0;
    end
  end

  // An overvoltage holds until start-up; a trip in the same cycle still wins.
  always_comb begin
    nxt_ovp = ovp_ff;
    if (enter_startup) begin
      nxt_ovp = 1'b0;
    end
    if (ovp_s) begin
      nxt_ovp = 1'b1;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // All control state returns to a fresh start-up in normal mode.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      phase_ff <= PH_STARTUP;
      osc_cnt_ff <= OSC_LAST;
      gate_ff <= 1'b0;
      end_status_ff <= END_STATUS_RST;
      mode_ff <= MODE_RST;
      ovp_ff <= 1'b0;
      pwm_seen_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      osc_cnt_ff <= nxt_osc_cnt;
      gate_ff <= nxt_gate;
      end_status_ff <= nxt_end_status;
      mode_ff <= nxt_mode;
      ovp_ff <= nxt_ovp;
      pwm_seen_ff <= nxt_pwm_seen;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Switch and source controls decode straight from registered state.
  // holds because start-up entry only clears the mode on the overcurrent value.
  assign gate_drive = gate_ff;
  assign startup_src_en = (phase_ff == PH_STARTUP);
  assign standby_ind = (phase_ff == PH_SWITCH) && mode_ff;
  assign cs_source_en = (phase_ff == PH_SWITCH) && mode_ff;
  assign sleep_bias_switch = (phase_ff == PH_LATCHED) && mode_ff;
  assign regulator_switch = (phase_ff == PH_SWITCH);
  assign mode_pulsed = mode_ff;
  assign end_status_latch = end_status_ff;
  assign overcurrent_flag = cs_s;
  assign no_overcurrent_flag = end_status_ff;
  assign ovp_latched = ovp_ff;
  assign phase = phase_ff;

  // ************************************************************
  // Checks
  // ************************************************************
  // The pulse never runs past the duty cap count.
  a_duty_cap_limit: assert property (@(posedge mclk) disable iff (!reset_n)
    gate_ff |-> (osc_cnt_ff <= ON_LAST))
    else $error("on-time passed the duty cap");
  // An overcurrent ending stores the overcurrent value next cycle.
  a_oc_status_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    (gate_ff && cs_s) |=> (!end_status_ff && !gate_ff))
    else $error("overcurrent ending not stored as zero");
  // A width ending without overcurrent stores the no-overcurrent value.
  a_pwm_status_one: assert property (@(posedge mclk) disable iff (!reset_n)
    (gate_ff && pwm_s && !cs_s) |=> end_status_ff)
    else $error("width ending not stored as one");
  // Lower working threshold moves switching to latched-off.
  a_low_work_exit: assert property (@(posedge mclk) disable iff (!reset_n)
    (phase_ff == PH_SWITCH && low_work_s) |=> (phase_ff == PH_LATCHED && !gate_ff))
    else $error("switching did not stop at the working threshold");
  // Restart threshold hands latched-off over to start-up.
  a_uvlo_restart: assert property (@(posedge mclk) disable iff (!reset_n)
    (phase_ff == PH_LATCHED && uvlo_s) |=> (phase_ff == PH_STARTUP && startup_src_en))
    else $error("latched-off did not restart");
  // Start threshold disables the source and enters switching.
  a_startup_exit: assert property (@(posedge mclk) disable iff (!reset_n)
    (phase_ff == PH_STARTUP && start_s) |=> (phase_ff == PH_SWITCH && !startup_src_en))
    else $error("start-up did not end at the start threshold");
  // Start-up after an overcurrent ending is in normal mode.
  a_mode_cleared: assert property (@(posedge mclk) disable iff (!reset_n)
    (phase_ff == PH_LATCHED && uvlo_s && !end_status_ff) |=> !mode_ff)
    else $error("mode latch not cleared at start-up");
  // Start-up after a no-overcurrent ending keeps the mode set.
  a_mode_kept: assert property (@(posedge mclk) disable iff (!reset_n)
    (phase_ff == PH_LATCHED && uvlo_s && end_status_ff && mode_ff
     && !direct_normal_reset) |=> mode_ff)
    else $error("mode latch lost at start-up");
  // Direct reset clears the mode within one cycle in any phase.
  a_direct_reset: assert property (@(posedge mclk) disable iff (!reset_n)
    direct_normal_reset |=> (!mode_ff && !standby_ind))
    else $error("direct reset did not return to normal");
  // Overvoltage in a switching phase that stays put keeps the output off.
  a_ovp_holds_off: assert property (@(posedge mclk) disable iff (!reset_n)
    (ovp_s && phase_ff == PH_SWITCH && !low_work_s) |=> (ovp_ff && !gate_ff) [*2])
    else $error("output not held off after overvoltage");
  // The oscillator waits at its last count until demagnetization completes.
  a_demag_wait: assert property (@(posedge mclk) disable iff (!reset_n)
    (phase_ff == PH_SWITCH && !low_work_s && osc_cnt_ff == OSC_LAST && !demag_complete)
    |=> (osc_cnt_ff == OSC_LAST && !gate_ff))
    else $error("oscillator ran before demagnetization");
  // A new pulse only starts at the beginning of an oscillator cycle.
  a_pulse_start: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(gate_ff) |-> (osc_cnt_ff == '0 && $past(demag_complete)))
    else $error("pulse began outside a cycle start");
  // Standby switching enables the sense-pin source from its first cycle.
  a_standby_source: assert property (@(posedge mclk) disable iff (!reset_n)
    (phase_ff == PH_STARTUP && start_s && mode_ff && !direct_normal_reset)
    |=> (standby_ind && cs_source_en && regulator_switch))
    else $error("standby switching without sense source");
  // Standby latched-off closes the sleep switch and opens the regulator.
  a_sleep_bias: assert property (@(posedge mclk) disable iff (!reset_n)
    (sw_exit && nxt_mode) |=> (sleep_bias_switch && !regulator_switch))
    else $error("sleep bias switch not closed in standby");
  // A switching phase with no width-side ending clears the status and never sets the mode.
  a_no_pwm_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    (sw_exit && !pwm_seen_ff && !(on_end && !cs_s))
    |=> (!end_status_ff && (!mode_ff || $past(mode_ff))))
    else $error("status not cleared after switching without width ending");

endmodule

`default_nettype wire

// file: bench/spms_plant.sv
// Behavioural model of the power switch, sense resistor and transformer seen by the sequencer.
`timescale 1ns/1ps
`default_nettype none

module spms_plant (
  input wire logic mclk,
  input wire logic gate_drive,
  input wire logic trip_en,
  input wire logic demag_en,
  output logic cs_trip,
  output logic demag_done
);
  int on_cnt = 0;
  int off_cnt = 0;

  // ************************************************************
  // Switch current and winding demagnetization
  // ************************************************************

  initial begin
    cs_trip = 1'b0;
    demag_done = 1'b1;
  end

  // Sense current ramps while the switch is on, so a trip comes two clocks into each pulse.
  // The winding stays magnetised during the on-time and two clocks after it, like a real core.
  always @(posedge mclk) begin
    #10;
    on_cnt = gate_drive ? on_cnt + 1 : 0;
    cs_trip = trip_en && (on_cnt >= 2);
    off_cnt = gate_drive ? 0 : off_cnt + 1;
    demag_done = demag_en && !gate_drive && (off_cnt >= 2);
  end
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the supply phase and mode sequencer.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import spms_pkg::*;
  localparam int OSC_P = 10;
  localparam int MAX_P = (OSC_P * MAX_DUTY_PCT) / PCT_FULL;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [8:0] cmp_tb = 9'h000;
  logic trip_en = 1'b0;
  logic demag_en = 1'b1;
  logic cs_trip;
  logic demag_done;
  logic [CMP_W-1:0] cmp_async;
  logic gate_drive, startup_src_en, cs_source_en, standby_ind, sleep_bias_switch;
  logic regulator_switch, mode_pulsed, end_status_latch, overcurrent_flag;
  logic no_overcurrent_flag, ovp_latched;
  spms_phase_t phase;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int len;
  int hi;

  // Sense trip and demag come from the plant model, the supply levels from the bench.
  assign cmp_async = {cmp_tb[8], demag_done, cmp_tb[6], cs_trip, cmp_tb[4:0]};

  spms_sequencer #(.OSC_PERIOD(OSC_P), .MAX_ON(MAX_P)) dut_u (
    .mclk(mclk), .reset_n(reset_n), .cmp_async(cmp_async), .gate_drive(gate_drive),
    .startup_src_en(startup_src_en), .cs_source_en(cs_source_en),
    .standby_ind(standby_ind), .sleep_bias_switch(sleep_bias_switch),
    .regulator_switch(regulator_switch), .mode_pulsed(mode_pulsed),
    .end_status_latch(end_status_latch), .overcurrent_flag(overcurrent_flag),
    .no_overcurrent_flag(no_overcurrent_flag), .ovp_latched(ovp_latched), .phase(phase)
  );

  spms_plant plant_u (
    .mclk(mclk), .gate_drive(gate_drive), .trip_en(trip_en), .demag_en(demag_en),
    .cs_trip(cs_trip), .demag_done(demag_done)
  );

  // ************************************************************
  // Clock, timeout and shared tasks
  // ************************************************************

  // Clock at 100 ns; the ceiling is far above the few hundred cycles the run needs.
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Inputs move 10 ns after the edge, so state written on that edge has settled too.
  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask

  // A level acts at the third edge, so four edges always cover the synchroniser.
  task automatic pulse_in(int b);
    cmp_tb[b] = 1'b1;
    step(4);
    cmp_tb[b] = 1'b0;
    step(2);
  endtask

  task automatic measure(output int n);
    int w;
    w = 0;
    n = 0;
    while (gate_drive !== 1'b1 && w < 100) begin
      step(1);
      w++;
    end
    while (gate_drive === 1'b1 && n < 50) begin
      step(1);
      n++;
    end
  endtask

  task automatic highs(int n, output int c);
    c = 0;
    repeat (n) begin
      step(1);
      if (gate_drive === 1'b1) c++;
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************

  task automatic t_start();
    check("rst_phase", 8'(phase), 8'(PH_STARTUP));
    check("rst_src", 8'(startup_src_en), 8'h01);
    check("rst_mode", 8'(mode_pulsed), 8'(MODE_RST));
    pulse_in(CMP_START);
    check("sw_phase", 8'(phase), 8'(PH_SWITCH));
    check("sw_src", 8'(startup_src_en), 8'h00);
    check("sw_reg", 8'(regulator_switch), 8'h01);
  endtask

  // Full-width pulses with no trip end at the cap and count as no overcurrent.
  task automatic t_cap_oc();
    measure(len);
    measure(len);
    check("cap_len", 8'(len), 8'(MAX_P));
    check("cap_status", 8'(end_status_latch), 8'h01);
    check("cap_noc", 8'(no_overcurrent_flag), 8'h01);
    check("cap_ocf", 8'(overcurrent_flag), 8'h00);
    trip_en = 1'b1;
    measure(len);
    measure(len);
    check("oc_flag", 8'(overcurrent_flag), 8'h01);
    check("oc_short", 8'(len < MAX_P), 8'h01);
    check("oc_status", 8'(end_status_latch), 8'h00);
    check("oc_cs_src", 8'(cs_source_en), 8'h00);
  endtask

  task automatic t_hold();
    demag_en = 1'b0;
    measure(len);
    highs(40, hi);
    check("hold_gate", 8'(hi), 8'h00);
    demag_en = 1'b1;
  endtask

  task automatic t_overload();
    pulse_in(CMP_LOW_WORK);
    check("ol_phase", 8'(phase), 8'(PH_LATCHED));
    check("ol_status", 8'(end_status_latch), 8'h00);
    check("ol_mode", 8'(mode_pulsed), 8'h00);
    pulse_in(CMP_UVLO);
    check("ol_rst_phase", 8'(phase), 8'(PH_STARTUP));
    check("ol_rst_src", 8'(startup_src_en), 8'h01);
    check("ol_rst_mode", 8'(mode_pulsed), 8'h00);
  endtask

  // Width-comparator endings in one burst carry the supply into pulsed standby.
  task automatic t_pulsed();
    trip_en = 1'b0;
    cmp_tb[CMP_PWM] = 1'b1;
    pulse_in(CMP_START);
    step(30);
    check("pm_status", 8'(end_status_latch), 8'h01);
    pulse_in(CMP_LOW_WORK);
    check("pm_mode", 8'(mode_pulsed), 8'h01);
    check("pm_sleep", 8'(sleep_bias_switch), 8'h01);
    check("pm_reg", 8'(regulator_switch), 8'h00);
    highs(20, hi);
    check("pm_off", 8'(hi), 8'h00);
    pulse_in(CMP_UVLO);
    check("pm_keep", 8'(mode_pulsed), 8'h01);
    pulse_in(CMP_START);
    check("pm_stby", 8'(standby_ind), 8'h01);
    check("pm_cs_src", 8'(cs_source_en), 8'h01);
    pulse_in(CMP_DEMAG_LOW);
    check("dr_mode", 8'(mode_pulsed), 8'h00);
    check("dr_stby", 8'(standby_ind), 8'h00);
  endtask

  // From pulsed standby, a switching phase with no pulse at all clears the status,
  // so the next start-up drops the mode latch and switching returns to normal.
  task automatic t_no_pwm();
    pulse_in(CMP_LOW_WORK);
    check("np_set", 8'(mode_pulsed), 8'h01);
    demag_en = 1'b0;
    pulse_in(CMP_UVLO);
    cmp_tb[CMP_PWM] = 1'b0;
    pulse_in(CMP_START);
    highs(20, hi);
    check("np_gate", 8'(hi), 8'h00);
    pulse_in(CMP_LOW_WORK);
    check("np_status", 8'(end_status_latch), 8'h00);
    check("np_mode", 8'(mode_pulsed), 8'h01);
    pulse_in(CMP_UVLO);
    check("np_mode2", 8'(mode_pulsed), 8'h00);
    demag_en = 1'b1;
    pulse_in(CMP_START);
    check("np_stby", 8'(standby_ind), 8'h00);
    check("np_cs_src", 8'(cs_source_en), 8'h00);
  endtask

  task automatic t_ovp();
    for (int b = CMP_VCC_OVER; b <= CMP_QOVP; b++) begin
      pulse_in(CMP_START);
      pulse_in(b);
      check("ovp_set", 8'(ovp_latched), 8'h01);
      highs(30, hi);
      check("ovp_gate", 8'(hi), 8'h00);
      pulse_in(CMP_LOW_WORK);
      pulse_in(CMP_UVLO);
      check("ovp_clr", 8'(ovp_latched), 8'h00);
    end
  endtask

  initial begin
    step(10);
    reset_n = 1'b1;
    step(2);
    t_start();
    t_cap_oc();
    t_hold();
    t_overload();
    t_pulsed();
    t_no_pwm();
    t_ovp();
    end_sim();
  end
endmodule
`default_nettype wire
